// ==== hdl/rffs_supervisor.sv ====
// fault supervisor: per channel timeouts, alarm patterns and 30% fallback
`timescale 1ns/1ps
`default_nettype none
module rffs_supervisor #(
    parameter int unsigned TICK_CYC     = rffs_pkg::TICK_CYC,
    parameter int unsigned SHORT_TICKS  = rffs_pkg::SHORT_TICKS,
    parameter int unsigned LONG_TICKS   = rffs_pkg::LONG_TICKS,
    parameter int unsigned FB_ON_TICKS  = rffs_pkg::FB_ON_TICKS,
    parameter int unsigned FB_PER_TICKS = rffs_pkg::FB_PER_TICKS
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // radio receiver, one strobe per channel (same clock)
    input  wire rffs_pkg::rffs_rx_t [3:0] rx_i,
    // channel configuration, held in non-volatile store outside
    input  wire logic [3:0]             learned_i,
    input  wire logic                   pump_mode_i,
    input  wire logic                   tswitch_mode_i,
    input  wire logic                   master_mode_i,
    // panel pins
    input  wire logic                   reset_btn_i,
    input  wire logic                   beeper_disable_jumper_i,
    // outputs
    output logic [3:0]                  relay_o,
    output logic [3:0]                  lamp_o,
    output logic                        beeper_o,
    output logic                        slave_comfort_o,
    output logic                        quit_modes_o,
    output logic [3:0]                  fault_o
);
    localparam int unsigned NCH = rffs_pkg::NUM_CH;
    localparam int unsigned TW  = $clog2(LONG_TICKS + 2);
    localparam int unsigned DW  = $clog2(TICK_CYC + 1);
    localparam int unsigned FW  = $clog2(FB_PER_TICKS + 1);

    // counters would wrap or never reach their end points with such values
    if (SHORT_TICKS == 0 || LONG_TICKS <= SHORT_TICKS || FB_ON_TICKS >= FB_PER_TICKS
        || TICK_CYC < 2)
    begin : g_bad_timing
        $error("rffs_supervisor: illegal timing parameters");
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    logic [1:0] btn_s_q;
    logic [1:0] jmp_s_q;
    logic       btn_prev_q;
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            btn_s_q    <= 2'h0;
            jmp_s_q    <= 2'h0;
            btn_prev_q <= 1'b0;
        end
        else
        begin
            btn_s_q    <= {btn_s_q[0], reset_btn_i};
            jmp_s_q    <= {jmp_s_q[0], beeper_disable_jumper_i};
            btn_prev_q <= btn_s_q[1];
        end
    end
    logic press;
    assign press = btn_s_q[1] && !btn_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // common slow tick
    logic [DW-1:0] div_q;
    logic          tick_q;
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (div_q == DW'(TICK_CYC - 1))
        begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q  <= div_q + DW'(1);
            tick_q <= 1'b0;
        end
    end

    // fallback period counter shared so all faulty channels switch in step
    logic [FW-1:0] fb_q;
    logic [4:0]    pat_q;
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fb_q  <= '0;
            pat_q <= '0;
        end
        else if (tick_q)
        begin
            fb_q  <= (fb_q == FW'(FB_PER_TICKS - 1)) ? '0 : fb_q + FW'(1);
            pat_q <= (pat_q == rffs_pkg::PAT_LEN - 5'h01) ? 5'h00 : pat_q + 5'h01;
        end
    end
    logic fb_on;
    assign fb_on = fb_q < FW'(FB_ON_TICKS);

    // flash pattern decode
    function automatic logic pat_lit(input rffs_pkg::rffs_fault_t f, input logic [4:0] p);
        logic a;
        logic b;
        a = p >= rffs_pkg::PULSE_A && p < rffs_pkg::PULSE_A + rffs_pkg::PULSE_W;
        b = p >= rffs_pkg::PULSE_B && p < rffs_pkg::PULSE_B + rffs_pkg::PULSE_W;
        unique case (f)
            rffs_pkg::RFFS_DOUBLE:     pat_lit = a || b;
            rffs_pkg::RFFS_LOSS_SHORT,
            rffs_pkg::RFFS_LOSS_LONG:  pat_lit = a;
            rffs_pkg::RFFS_OK:         pat_lit = 1'b0;
        endcase
    endfunction : pat_lit

    ////////////////////////////////////////////////////////////////////////////
    // per channel supervision
    rffs_pkg::rffs_fault_t fault_q [NCH];
    logic [TW-1:0]         age_q   [NCH];
    logic [NCH-1:0]        demand_q;
    logic [NCH-1:0]        alarm;
    logic [NCH-1:0]        beep_req;
    logic [NCH-1:0]        out_eff;

    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            always_ff @(posedge clk_i or negedge rst_n)
            begin
                if (!rst_n)
                    age_q[g] <= '0;
                else if (!learned_i[g] || rx_i[g].valid)
                    age_q[g] <= '0;
                else if (tick_q && age_q[g] <= TW'(LONG_TICKS))
                    age_q[g] <= age_q[g] + TW'(1);
            end

            always_ff @(posedge clk_i or negedge rst_n)
            begin
                if (!rst_n)
                    fault_q[g] <= rffs_pkg::RFFS_OK;
                else if (!learned_i[g])
                    fault_q[g] <= rffs_pkg::RFFS_OK;
                else if (rx_i[g].valid && rx_i[g].conflict)
                    fault_q[g] <= rffs_pkg::RFFS_DOUBLE;
                else if (fault_q[g] == rffs_pkg::RFFS_DOUBLE)
                    fault_q[g] <= rffs_pkg::RFFS_DOUBLE;
                else if (rx_i[g].valid)
                    fault_q[g] <= rffs_pkg::RFFS_OK;
                else if (age_q[g] > TW'(LONG_TICKS))
                    fault_q[g] <= rffs_pkg::RFFS_LOSS_LONG;
                else if (age_q[g] >= TW'(SHORT_TICKS))
                    fault_q[g] <= rffs_pkg::RFFS_LOSS_SHORT;
            end

            // learned links live outside, so a press only drops demand
            always_ff @(posedge clk_i or negedge rst_n)
            begin
                if (!rst_n)
                    demand_q[g] <= 1'b0;
                else if (press)
                    demand_q[g] <= 1'b0;
                else if (rx_i[g].valid && !rx_i[g].conflict)
                    demand_q[g] <= rx_i[g].demand;
            end

            assign alarm[g]    = fault_q[g] != rffs_pkg::RFFS_OK;
            assign beep_req[g] = fault_q[g] == rffs_pkg::RFFS_DOUBLE
                              || fault_q[g] == rffs_pkg::RFFS_LOSS_LONG;
            assign out_eff[g]  = alarm[g] ? fb_on : demand_q[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // output mapping
    logic [NCH-1:0] relay_d;
    logic [NCH-1:0] lamp_d;
    always_comb
    begin
        relay_d = out_eff;
        // time switch outputs on 2 and 4 keep their own demand but fall back on alarms of channels 1 and 3; pump mode still drives 4
        if (tswitch_mode_i)
        begin
            relay_d[1] = alarm[0] ? fb_on : demand_q[1];
            relay_d[3] = alarm[2] ? fb_on : demand_q[3];
        end
        if (pump_mode_i)
            relay_d[3] = (|out_eff[2:0]) || (|alarm[2:0]);
        for (int i = 0; i < NCH; i++)
            lamp_d[i] = alarm[i] ? pat_lit(fault_q[i], pat_q) : relay_d[i];
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            relay_o <= '0;
            lamp_o  <= '0;
        end
        else
        begin
            relay_o <= relay_d;
            lamp_o  <= lamp_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            beeper_o        <= 1'b0;
            slave_comfort_o <= 1'b0;
            quit_modes_o    <= 1'b0;
            fault_o         <= '0;
        end
        else
        begin
            beeper_o        <= (|beep_req) && !jmp_s_q[1];
            slave_comfort_o <= master_mode_i && alarm[0];
            quit_modes_o    <= press;
            fault_o         <= alarm;
        end
    end
    // no volatile configuration here; it is read back from learned_i and the mode inputs

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_beeper_jumper_mute: assert property (@(posedge clk_i) disable iff (!rst_n)
        jmp_s_q[1] |=> !beeper_o)
        else $error("beeper sounds with jumper removed");
    chk_press_drops_relay: assert property (@(posedge clk_i) disable iff (!rst_n)
        press && !pump_mode_i && !tswitch_mode_i && alarm == '0 ##1 !(|rx_i[0].valid)
        |=> relay_o[0] == 1'b0)
        else $error("relay not dropped after reset press");
    chk_double_beeps: assert property (@(posedge clk_i) disable iff (!rst_n)
        fault_q[0] == rffs_pkg::RFFS_DOUBLE && !jmp_s_q[1] |=> beeper_o)
        else $error("double addressing silent");
    chk_short_silent: assert property (@(posedge clk_i) disable iff (!rst_n)
        (beep_req == '0) |=> !beeper_o)
        else $error("beeper without cause");
    chk_fallback_duty: assert property (@(posedge clk_i) disable iff (!rst_n)
        alarm[0] |=> relay_o[0] == $past(fb_on))
        else $error("fallback duty not applied");
    chk_rx_clears_loss: assert property (@(posedge clk_i) disable iff (!rst_n)
        learned_i[0] && rx_i[0].valid && !rx_i[0].conflict
        && fault_q[0] != rffs_pkg::RFFS_DOUBLE |=> fault_q[0] == rffs_pkg::RFFS_OK)
        else $error("loss alarm not cleared");
    chk_pump_alarm_on: assert property (@(posedge clk_i) disable iff (!rst_n)
        pump_mode_i && (|alarm[2:0]) |=> relay_o[3])
        else $error("pump off during alarm");
    chk_slave_comfort: assert property (@(posedge clk_i) disable iff (!rst_n)
        master_mode_i && alarm[0] |=> slave_comfort_o)
        else $error("slaves not in comfort");
    chk_long_loss_set: assert property (@(posedge clk_i) disable iff (!rst_n)
        learned_i[0] && !rx_i[0].valid && age_q[0] > TW'(LONG_TICKS)
        && fault_q[0] != rffs_pkg::RFFS_DOUBLE |=> fault_q[0] == rffs_pkg::RFFS_LOSS_LONG)
        else $error("long loss not flagged");
    chk_quit_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n)
        quit_modes_o |=> !quit_modes_o)
        else $error("quit pulse longer than one cycle");
endmodule : rffs_supervisor
`default_nettype wire

// ==== hdl/rffs_pkg.sv ====
// package: constants and carrier types for the receiver fault supervisor
package rffs_pkg;
    localparam int unsigned NUM_CH       = 4;
    localparam int unsigned CLK_HZ       = 200_000_000;
    // slow tick period in milliseconds
    localparam int unsigned TICK_MS      = 100;
    localparam int unsigned TICK_CYC     = (CLK_HZ / 1000) * TICK_MS;
    // supervision times in minutes and hours
    localparam int unsigned FB_ON_MIN    = 3;
    localparam int unsigned FB_OFF_MIN   = 7;
    localparam int unsigned SHORT_LOSS_H = 1;
    localparam int unsigned LONG_LOSS_H  = 10;
    localparam int unsigned TICKS_PER_S  = 1000 / TICK_MS;
    localparam int unsigned FB_ON_TICKS  = FB_ON_MIN * 60 * TICKS_PER_S;
    localparam int unsigned FB_PER_TICKS = (FB_ON_MIN + FB_OFF_MIN) * 60 * TICKS_PER_S;
    localparam int unsigned SHORT_TICKS  = SHORT_LOSS_H * 3600 * TICKS_PER_S;
    localparam int unsigned LONG_TICKS   = LONG_LOSS_H * 3600 * TICKS_PER_S;
    // flash pattern slot timing in ticks
    localparam int unsigned PAT_TICKS    = 30;
    localparam logic [4:0]  PAT_LEN      = 5'h1e;
    localparam logic [4:0]  PULSE_A      = 5'h00;
    localparam logic [4:0]  PULSE_B      = 5'h03;
    localparam logic [4:0]  PULSE_W      = 5'h02;
    localparam int unsigned TMR_W        = 20;

    typedef enum logic [1:0] {
        RFFS_OK,
        RFFS_DOUBLE,
        RFFS_LOSS_SHORT,
        RFFS_LOSS_LONG
    } rffs_fault_t;

    typedef struct packed {
        logic valid;
        logic demand;
        logic conflict;
    } rffs_rx_t;
endpackage : rffs_pkg

// ==== test/rffs_tx_model.sv ====
// transmitter model: periodic telegrams for one receive channel
`timescale 1ns/1ps
`default_nettype none
module rffs_tx_model (
    // clock and bench controls
    input  wire logic              clk_i,
    input  wire logic              en_i,
    input  wire logic              dbl_i,
    input  wire logic              dem_i,
    // telegram towards the receiver
    output var rffs_pkg::rffs_rx_t rx_o
);
    logic [3:0] gap_q = 4'h0;
    // valve protection is off, so no daily forced demand is sent
    always @(negedge clk_i)
    begin
        gap_q <= gap_q + 4'h1;
        rx_o.valid <= en_i && (gap_q == 4'h0);
        // idle fields toggle so a stale value is never trusted
        rx_o.demand <= (en_i && gap_q == 4'h0) ? dem_i : ~rx_o.demand;
        rx_o.conflict <= (en_i && gap_q == 4'h0) ? dbl_i : ~rx_o.conflict;
    end
endmodule : rffs_tx_model
`default_nettype wire

// ==== test/testbench.sv ====
// testbench: fault supervisor against four transmitter models
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // shortened counts: one tick is four cycles
    localparam int unsigned TCK   = 4;
    localparam int unsigned PER   = 10 * TCK;
    localparam int unsigned FRM   = rffs_pkg::PAT_TICKS * TCK;
    localparam logic [7:0]  FB_HI = 8'(3 * TCK);
    logic clk = 1'b0, rst_n = 1'b0, btn = 1'b0, jmp = 1'b0;
    logic pump = 1'b0, tsw = 1'b0, mst = 1'b0;
    logic [3:0] lrn = 4'hf, en = 4'hf, dbl = 4'h0, dem = 4'h0;
    logic [3:0] relay, lamp, fault;
    logic       beep, comfort, quit;
    logic [7:0] hi;
    integer     seed = 32'h8cb4_223a;
    int         n_mismatch = 0;
    int         n_compared = 0;
    wire logic [7:0] outs = {lamp, relay};
    wire rffs_pkg::rffs_rx_t [3:0] rx;

    ////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < 4; g++)
    begin : g_tx
        rffs_tx_model i_rffs_tx_model (.clk_i(clk), .en_i(en[g]), .dbl_i(dbl[g]),
            .dem_i(dem[g]), .rx_o(rx[g]));
    end
    rffs_supervisor #(.TICK_CYC(TCK), .SHORT_TICKS(10), .LONG_TICKS(20),
        .FB_ON_TICKS(3), .FB_PER_TICKS(10)) i_rffs_supervisor (.clk_i(clk),
        .rst_n_i(rst_n), .rx_i(rx), .learned_i(lrn), .pump_mode_i(pump),
        .tswitch_mode_i(tsw), .master_mode_i(mst), .reset_btn_i(btn),
        .beeper_disable_jumper_i(jmp), .relay_o(relay), .lamp_o(lamp),
        .beeper_o(beep), .slave_comfort_o(comfort), .quit_modes_o(quit),
        .fault_o(fault));

    ////////////////////////////////////////////////////////////////
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // high cycles of one relay or lamp over a window
    task automatic cnt(int sel, int len);
        hi = 8'h00;
        repeat (len)
        begin
            @(negedge clk);
            hi = hi + 8'(outs[sel]);
        end
    endtask : cnt
    // lit cycles per frame: pulse of two ticks, second pulse if double
    function automatic logic [7:0] lamp_hi(logic two);
        return 8'((two ? 2 : 1) * rffs_pkg::PULSE_W * TCK);
    endfunction : lamp_hi
    // new random demands, then healthy channels must follow them
    task automatic normal(logic [3:0] mask);
        dem = 4'($random(seed));
        cyc(PER);
        for (int c = 0; c < 4; c++)
            if (mask[c])
            begin
                chk("relay", relay[c], dem[c]);
                chk("lamp", lamp[c], dem[c]);
            end
    endtask : normal
    task automatic end_of_test();
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // whole run is near 1040 cycles; this leaves ample margin
    initial
    begin
        #50us;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        cyc(20);
        rst_n = 1'b1;
        cyc(10);
        repeat (4) normal(4'hf);
        // double addressing on channel 1
        dbl[0] = 1'b1;
        cyc(10);
        chk("fault", fault, 4'h1);
        chk("beep", beep, 1);
        cnt(4, FRM);
        chk("lamp hi", hi, lamp_hi(1));
        cnt(0, PER);
        chk("relay hi", hi, FB_HI);
        normal(4'he);
        jmp = 1'b1;
        cyc(10);
        chk("beep", beep, 0);
        cnt(4, FRM);
        chk("lamp hi", hi, lamp_hi(1));
        dbl[0] = 1'b0;
        cyc(PER);
        chk("fault", fault, 4'h1);
        lrn[0] = 1'b0;
        cyc(5);
        lrn[0] = 1'b1;
        jmp = 1'b0;
        cyc(PER);
        chk("fault", fault, 4'h0);
        // reset press with no telegram in flight
        dem = 4'hf;
        cyc(PER);
        en = 4'h0;
        btn = 1'b1;
        for (int i = 0; i < 10 && quit !== 1'b1; i++)
            cyc(1);
        chk("quit", quit, 1);
        cyc(1);
        chk("quit", quit, 0);
        cyc(2);
        chk("relay", relay, 4'h0);
        btn = 1'b0;
        en = 4'hf;
        cyc(PER);
        chk("relay", relay, 4'hf);
        // signal loss on channel 1 with all modes on
        {pump, tsw, mst} = 3'b111;
        en[0] = 1'b0;
        cyc(8);
        chk("fault", fault, 4'h0);
        cyc(48);
        chk("fault", fault, 4'h1);
        chk("beep", beep, 0);
        chk("comfort", comfort, 1);
        chk("pump", relay[3], 1);
        cnt(4, FRM);
        chk("lamp hi", hi, lamp_hi(0));
        chk("beep", beep, 1);
        cnt(0, PER);
        chk("relay hi", hi, FB_HI);
        cnt(1, PER);
        chk("tswitch hi", hi, FB_HI);
        en[0] = 1'b1;
        cyc(PER);
        chk("fault", fault, 4'h0);
        chk("comfort", comfort, 0);
        {pump, tsw, mst} = 3'b000;
        // power loss in mid run keeps the configuration
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
        normal(4'hf);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
